// ===== shared/kme_pkg.sv
// Package with the constants and carrier types of the keyboard matrix encoder.
package kme_pkg;
  localparam int DRIVE_LINES = 11;
  localparam int SENSE_LINES = 8;
  localparam int ASCII_DRIVES = 7;
  localparam int CODE_W = 8;
  localparam logic [7:0] HEX_BASE = 8'h80;
  localparam logic [7:0] CTRL_MASK = 8'h1F;
  localparam logic [7:0] CASE_BIT = 8'h20;
  localparam logic [7:0] SEL_MATCH = 8'h00;
  // Modifier classes of the decoder.
  typedef enum logic [3:0] {
    KME_MOD_NORMAL = 4'h1,
    KME_MOD_ALPHA = 4'h2,
    KME_MOD_SHIFT = 4'h4,
    KME_MOD_CTRL = 4'h8
  } kme_mod_t;
  // One captured key code with its position.
  typedef struct packed {
    logic [7:0] code;
    logic [3:0] drive;
    logic [2:0] sense;
  } kme_key_t;
endpackage

// ===== src/kme_buf2.sv
// Two-entry valid/ready buffer that holds captured key codes.
`timescale 1ns/1ps
module kme_buf2 #(
  parameter int WIDTH = 15
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_ff [2];
  logic [WIDTH-1:0] nxt_mem [2];
  logic [1:0] cnt_ff, nxt_cnt;
  logic wr_ptr_ff, nxt_wr_ptr, rd_ptr_ff, nxt_rd_ptr;
  logic push, pop;

  initial begin
    if (WIDTH < 1) $error("kme_buf2: WIDTH must be positive.");
  end

  assign in_ready = (cnt_ff != 2'h2);
  assign out_valid = (cnt_ff != 2'h0);
  assign out_data = mem_ff[rd_ptr_ff];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next pointer, count and storage values.
  always_comb begin
    nxt_mem = mem_ff;
    nxt_wr_ptr = wr_ptr_ff;
    nxt_rd_ptr = rd_ptr_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_mem[wr_ptr_ff] = in_data;
      nxt_wr_ptr = ~wr_ptr_ff;
    end
    if (pop) begin
      nxt_rd_ptr = ~rd_ptr_ff;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 2'h1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 2'h1;
    end
  end

  // Register the buffer state.
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_ff[0] <= '0;
      mem_ff[1] <= '0;
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      cnt_ff <= 2'h0;
    end else begin
      mem_ff <= nxt_mem;
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule // kme_buf2

// ===== src/kme_encoder.sv
// Keyboard matrix scan encoder with modifier decoding and a three-state host byte.
`timescale 1ns/1ps
module kme_encoder #(
  parameter int DRIVES = kme_pkg::DRIVE_LINES,
  parameter int SENSES = kme_pkg::SENSE_LINES
) (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // Key matrix.
  output logic [10:0] KEY_DRIVE,
  input wire logic [7:0] KEY_SENSE,
  // Modifier inputs.
  input wire logic SHIFT_IN,
  input wire logic CTRL_IN,
  input wire logic CAPS_LOCK_IN,
  // Debounce node, high once the external delay has elapsed after release.
  input wire logic DEBOUNCE_IN,
  output logic DEBOUNCE_DISCHARGE,
  // Host interface.
  input wire logic HOST_TIMING_PULSE,
  input wire logic [3:0] DEV_SELECT_INPUTS,
  output logic [7:0] HOST_DATA_OUT,
  output logic HOST_DATA_OE,
  output logic KEY_READY_N,
  output logic KEY_HELD_N
);
  // Operation overview.
  // The scan position is a drive index and a sense index held in flip-flops.
  // The drive index selects one of the eleven drive lines and holds it high.
  // The sense index selects which sense input is examined on each step.
  // Scanning advances only on a sampled fall of the host timing pulse.
  // A closed switch seen on a sampled rise of the pulse starts a keydown check.
  // During that check the debounce node is discharged.
  // The check ends on the next pulse rise that finds the node low and the key closed.
  // At that edge the code is captured and the ready flag is driven low.
  // The captured code passes through a two-entry buffer into the output register.
  // The output register keeps its code until the host has read it.
  // A host read is a pulse rise seen while all four selects match.
  // The read returns the ready flag high and marks the code as read.
  // While the key stays closed after the read, the held flag is low.
  // The held flag lets the host time an autorepeat of its own.
  // Opening the key stops the discharge so the external network recharges.
  // The release counts as complete only when the node reads high again.
  // A bounce that closes the key during recharge restarts the discharge.
  // After a complete release and a read, the next pulse fall resumes scanning.
  // A key pressed again after a complete release and a read is a fresh keydown.
  // Scanning stays frozen from capture to resumption, which locks out other keys.
  // So only the first closed key in scan order is reported until scanning resumes.
  // A second key held through the release is found when scanning reaches it.
  // Modifier handling.
  // Control and shift are sampled at the capture edge and kept in latches.
  // The code is decoded from the same levels, so it matches the latched class.
  // The latches are cleared once scanning resumes, ready for the next key.
  // Alpha lock is taken straight from its pin and is never latched.
  // Control outranks shift, shift outranks alpha lock, and none gives normal codes.
  // The modifiers never start a keydown check on their own.
  // Code table.
  // Lines one and two carry digits and punctuation, and shift flips bit four.
  // Lines three to six carry the letters and a few symbols.
  // Letters take lower case when plain and upper case with shift or alpha lock.
  // The symbols in that range take their second form only with shift.
  // Control keeps the low five bits of the upper case code.
  // Line seven carries space, line feed, escape, carriage return and delete.
  // Lines eight to eleven carry the hex codes, eight to a line.
  // Scan order.
  // The sense index runs fastest and wraps onto the next drive line.
  // After the last line the drive index returns to the first.
  // One full sweep takes eighty-eight pulse periods.
  // The order defines which of several closed keys is reported first.
  // Reset.
  // Reset leaves the ready and held flags high and the output register clear.
  // Reset also parks the scan on the first key of line one.
  // Buffering.
  // The buffer lets a capture complete even while the output register is busy.
  // With lockout in force it never holds more than one code.
  // Host side.
  // The output enable follows the selects directly, so the byte appears at once.
  // The byte itself changes only after the previous code has been read.
  // Debounce side.
  // The node input is low while the capacitor is discharged or still charging.
  // It goes high only once the external delay has run out.
  // The delay is set wholly outside, so no count of it lives here.
  // Limitations.
  // The pulse is sampled by the system clock, so each level must last at least one cycle.
  // A capture and a read on the same pulse rise keep the capture.
  // Scan phases.
  typedef enum logic [3:0] {
    ST_SCAN = 4'h1,
    ST_DEBOUNCE = 4'h2,
    ST_HOLD = 4'h4,
    ST_RELEASE = 4'h8
  } kme_state_t;

  initial begin
    if (DRIVES != kme_pkg::DRIVE_LINES || SENSES != kme_pkg::SENSE_LINES)
      $error("kme_encoder: matrix must be eleven by eight.");
  end

  // True for the keys of lines three to six that carry letters rather than symbols.
  function automatic logic is_letter(input logic [3:0] drv, input logic [2:0] sns);
    logic sym;
    sym = 1'b0;
    if (drv == 4'h2 && sns == 3'h0) sym = 1'b1;
    if (drv == 4'h5 && sns >= 3'h3) sym = 1'b1;
    is_letter = !sym;
  endfunction

  // Modifier class from control, shift and alpha lock levels, control first.
  function automatic kme_pkg::kme_mod_t mod_class(input logic ctl, input logic shf, input logic alp);
    if (ctl) begin
      mod_class = kme_pkg::KME_MOD_CTRL;
    end else if (shf) begin
      mod_class = kme_pkg::KME_MOD_SHIFT;
    end else if (alp) begin
      mod_class = kme_pkg::KME_MOD_ALPHA;
    end else begin
      mod_class = kme_pkg::KME_MOD_NORMAL;
    end
  endfunction

  // Map a matrix position and modifier class to its key code.
  function automatic logic [7:0] key_code(input logic [3:0] drv, input logic [2:0] sns,
                                          input kme_pkg::kme_mod_t md);
    logic [7:0] base;
    logic [7:0] pos;
    logic [3:0] hex_line;
    logic letter;
    base = 8'h00;
    pos = {1'b0, drv, sns};
    hex_line = drv - 4'(kme_pkg::ASCII_DRIVES);
    letter = is_letter(drv, sns);
    if (drv >= 4'(kme_pkg::ASCII_DRIVES)) begin
      // Each hex line owns eight consecutive codes in sense order.
      key_code = kme_pkg::HEX_BASE + {1'b0, hex_line, sns};
    end else begin
      unique case (drv)
        4'h0, 4'h1: begin
          // Digits sit at their own code; the last four keys of line two are punctuation sixteen lower.
          base = 8'h30 + pos;
          if (drv == 4'h1 && sns >= 3'h4) base = base ^ 8'h10;
          if (md == kme_pkg::KME_MOD_SHIFT) base = base ^ 8'h10;
        end
        4'h2, 4'h3, 4'h4, 4'h5: begin
          // Upper case codes run on from the position; the case bit depends on the class.
          base = 8'h40 + pos - 8'h10;
          if (md == kme_pkg::KME_MOD_NORMAL && letter) base = base | kme_pkg::CASE_BIT;
          if (md == kme_pkg::KME_MOD_SHIFT && !letter) base = base | kme_pkg::CASE_BIT;
          if (md == kme_pkg::KME_MOD_CTRL) base = base & kme_pkg::CTRL_MASK;
        end
        default: begin
          // Line seven holds the named control keys; other positions give no code.
          case (sns)
            3'h0: base = 8'h20;
            3'h2: base = 8'h0A;
            3'h3: base = 8'h1B;
            3'h5: base = 8'h0D;
            3'h7: base = 8'h7F;
            default: base = 8'h00;
          endcase
        end
      endcase
      key_code = base;
    end
  endfunction

  logic tp_ff, tp_rise, tp_fall;
  logic [3:0] drv_ff, nxt_drv;
  logic [2:0] sns_ff, nxt_sns;
  kme_state_t st_ff, nxt_st;
  logic ready_ff, nxt_ready, held_ff, nxt_held, read_done_ff, nxt_read_done;
  logic shift_lat_ff, nxt_shift_lat, ctrl_lat_ff, nxt_ctrl_lat;
  logic [7:0] out_ff, nxt_out;
  logic out_full_ff, nxt_out_full;
  logic selected, key_hit;
  kme_pkg::kme_mod_t mod_now;
  kme_pkg::kme_key_t cap;
  logic buf_in_ready, buf_out_valid, buf_pop;
  kme_pkg::kme_key_t buf_out;

  // Pulse edges; the pulse is the only scan pace.
  assign tp_rise = HOST_TIMING_PULSE && !tp_ff;
  assign tp_fall = !HOST_TIMING_PULSE && tp_ff;
  assign selected = (DEV_SELECT_INPUTS == 4'hE);
  assign key_hit = KEY_SENSE[sns_ff];
  // The node is discharged while a keydown is checked or a captured key stays closed.
  assign DEBOUNCE_DISCHARGE = (st_ff == ST_DEBOUNCE) || (st_ff == ST_HOLD && key_hit);

  // Modifier class of the latched key, with alpha lock taken live.
  assign mod_now = mod_class(ctrl_lat_ff, shift_lat_ff, CAPS_LOCK_IN);

  // The captured code is decoded from the modifier levels sampled at the capture edge.
  assign cap.drive = drv_ff;
  assign cap.sense = sns_ff;
  assign cap.code = key_code(drv_ff, sns_ff, mod_class(CTRL_IN, SHIFT_IN, CAPS_LOCK_IN));

  // One-hot drive of the current scan line.
  always_comb begin
    KEY_DRIVE = 11'h000;
    KEY_DRIVE[drv_ff] = 1'b1;
  end

  kme_buf2 #(.WIDTH($bits(kme_pkg::kme_key_t))) u_buf (
    .clk(REF_CLK),
    .rst(RST),
    .in_valid(st_ff == ST_DEBOUNCE && tp_rise && !DEBOUNCE_IN && key_hit),
    .in_ready(buf_in_ready),
    .in_data(cap),
    .out_valid(buf_out_valid),
    .out_ready(buf_pop),
    .out_data(buf_out)
  );
  // The output register takes a new code only once the previous one has been read.
  assign buf_pop = buf_out_valid && !out_full_ff;

  // Scan, capture and flag next values.
  always_comb begin
    nxt_st = st_ff;
    nxt_drv = drv_ff;
    nxt_sns = sns_ff;
    nxt_ready = ready_ff;
    nxt_held = held_ff;
    nxt_read_done = read_done_ff;
    nxt_shift_lat = shift_lat_ff;
    nxt_ctrl_lat = ctrl_lat_ff;
    nxt_out = out_ff;
    nxt_out_full = out_full_ff;
    unique case (st_ff)
      ST_SCAN: begin
        if (key_hit && tp_rise) begin
          nxt_st = ST_DEBOUNCE;
        end else if (tp_fall) begin
          if (sns_ff == 3'(SENSES - 1)) begin
            nxt_sns = 3'h0;
            nxt_drv = (drv_ff == 4'(DRIVES - 1)) ? 4'h0 : drv_ff + 4'h1;
          end else begin
            nxt_sns = sns_ff + 3'h1;
          end
        end
      end
      ST_DEBOUNCE: begin
        if (!key_hit) begin
          nxt_st = ST_SCAN;
        end else if (!DEBOUNCE_IN && tp_rise && buf_in_ready) begin
          nxt_shift_lat = SHIFT_IN;
          nxt_ctrl_lat = CTRL_IN;
          nxt_ready = 1'b0;
          nxt_read_done = 1'b0;
          nxt_st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (!key_hit && DEBOUNCE_IN) begin
          nxt_st = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (key_hit && read_done_ff) begin
          // A complete release and a read followed by a closure is a fresh keydown.
          nxt_st = ST_DEBOUNCE;
        end else if (key_hit) begin
          nxt_st = ST_HOLD;
        end else if (read_done_ff && tp_fall) begin
          nxt_st = ST_SCAN;
        end
      end
      default: nxt_st = ST_SCAN;
    endcase
    // Load the output register from the buffer; a read frees it for the next code.
    if (selected && tp_rise) nxt_out_full = 1'b0;
    if (buf_pop) begin
      nxt_out = buf_out.code;
      nxt_out_full = 1'b1;
    end
    // A selected read on the pulse rise clears the flag; a capture the same edge wins.
    if (selected && tp_rise && !(st_ff == ST_DEBOUNCE && nxt_st == ST_HOLD)) begin
      nxt_ready = 1'b1;
      nxt_read_done = 1'b1;
    end
    nxt_held = !(nxt_read_done && nxt_ready && (nxt_st == ST_HOLD));
    // Latches are dropped once scanning runs again.
    if (mod_now != kme_pkg::KME_MOD_NORMAL && st_ff == ST_SCAN) begin
      nxt_shift_lat = 1'b0;
      nxt_ctrl_lat = 1'b0;
    end
  end

  // Register the scan and flag state.
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      tp_ff <= 1'b0;
      st_ff <= ST_SCAN;
      drv_ff <= 4'h0;
      sns_ff <= 3'h0;
      ready_ff <= 1'b1;
      held_ff <= 1'b1;
      read_done_ff <= 1'b1;
      shift_lat_ff <= 1'b0;
      ctrl_lat_ff <= 1'b0;
      out_ff <= 8'h00;
      out_full_ff <= 1'b0;
    end else begin
      tp_ff <= HOST_TIMING_PULSE;
      st_ff <= nxt_st;
      drv_ff <= nxt_drv;
      sns_ff <= nxt_sns;
      ready_ff <= nxt_ready;
      held_ff <= nxt_held;
      read_done_ff <= nxt_read_done;
      shift_lat_ff <= nxt_shift_lat;
      ctrl_lat_ff <= nxt_ctrl_lat;
      out_ff <= nxt_out;
      out_full_ff <= nxt_out_full;
    end
  end

  // Host byte is enabled only while selected.
  assign HOST_DATA_OE = selected;
  assign HOST_DATA_OUT = out_ff;
  assign KEY_READY_N = ready_ff;
  assign KEY_HELD_N = held_ff;
endmodule // kme_encoder

// ===== dv/kme_kbd_model.sv
// Key matrix and debounce network model.
`timescale 1ns/1ps
module kme_kbd_model (
  // Clock.
  input wire logic clk,
  // Closed keys as drive*8+sense.
  input wire logic [6:0] key_a,
  input wire logic [6:0] key_b,
  input wire logic [1:0] key_on,
  // Matrix and debounce node.
  input wire logic [10:0] drive,
  output logic [7:0] sense,
  input wire logic discharge,
  output logic debounce
);
  logic [4:0] cnt_ff = 5'h1F;
  // A closed switch couples its driven line to a sense line.
  always_comb begin
    sense = 8'h00;
    if (key_on[0] && drive[key_a[6:3]]) sense[key_a[2:0]] = 1'b1;
    if (key_on[1] && drive[key_b[6:3]]) sense[key_b[2:0]] = 1'b1;
  end
  // The capacitor drops at once and recharges slowly.
  always_ff @(posedge clk) begin
    if (discharge) cnt_ff <= 5'h00;
    else if (cnt_ff != 5'h1F) cnt_ff <= cnt_ff + 5'h01;
  end
  assign debounce = !discharge && cnt_ff == 5'h1F;
endmodule // kme_kbd_model

// ===== dv/kme_sva.sv
// Port checker for the key encoder.
`timescale 1ns/1ps
module kme_sva (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RST,
  // Watched ports.
  input wire logic [10:0] KEY_DRIVE,
  input wire logic HOST_TIMING_PULSE,
  input wire logic [3:0] DEV_SELECT_INPUTS,
  input wire logic DEBOUNCE_DISCHARGE,
  input wire logic HOST_DATA_OE,
  input wire logic KEY_READY_N,
  input wire logic KEY_HELD_N
);
  logic sel;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  // Host read decode.
  assign sel = DEV_SELECT_INPUTS == 4'hE;
  oe_select_a: assert property (HOST_DATA_OE == sel) else $error("Enable wrong.");
  drive_onehot_a: assert property ($onehot(KEY_DRIVE)) else $error("Drive not one-hot.");
  ready_clear_a: assert property (!KEY_READY_N && sel && HOST_TIMING_PULSE && !$past(HOST_TIMING_PULSE)
    |=> KEY_READY_N) else $error("Ready not cleared.");
  ready_keep_a: assert property (!KEY_READY_N && !(sel && HOST_TIMING_PULSE) |=> !KEY_READY_N)
    else $error("Ready lost.");
  ready_set_a: assert property ($fell(KEY_READY_N) |-> $past(DEBOUNCE_DISCHARGE)) else $error("Early ready.");
  scan_freeze_a: assert property (!KEY_READY_N |=> $stable(KEY_DRIVE)) else $error("Scan moved.");
  drive_step_a: assert property ($changed(KEY_DRIVE) |-> !$past(HOST_TIMING_PULSE) && $past(HOST_TIMING_PULSE, 2))
    else $error("Drive moved off a fall.");
  held_read_a: assert property (!KEY_HELD_N |-> KEY_READY_N) else $error("Held before read.");
  // Main scenarios.
  cover property (sel && !KEY_READY_N);
  cover property ($fell(KEY_HELD_N));
  cover property ($rose(KEY_READY_N));
endmodule // kme_sva
bind kme_encoder kme_sva u_sva (.REF_CLK(REF_CLK), .RST(RST), .KEY_DRIVE(KEY_DRIVE),
  .HOST_TIMING_PULSE(HOST_TIMING_PULSE), .DEV_SELECT_INPUTS(DEV_SELECT_INPUTS),
  .DEBOUNCE_DISCHARGE(DEBOUNCE_DISCHARGE), .HOST_DATA_OE(HOST_DATA_OE), .KEY_READY_N(KEY_READY_N),
  .KEY_HELD_N(KEY_HELD_N));

// ===== dv/tb_top.sv
// Self-checking bench for the key encoder.
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0, rst = 1'b1, htp = 1'b0, shift = 1'b0, ctrl = 1'b0, caps = 1'b0;
  logic dis, deb, oe, rdy_n, held_n;
  logic [3:0] sel = 4'hF;
  logic [6:0] ka = 7'h00, kb = 7'h00;
  logic [1:0] kon = 2'h0;
  logic [10:0] drv;
  logic [7:0] sns, dout;
  int mismatches = 0, checks = 0, cyc = 0;
  kme_encoder dut (.REF_CLK(clk), .RST(rst), .KEY_DRIVE(drv), .KEY_SENSE(sns), .SHIFT_IN(shift),
    .CTRL_IN(ctrl), .CAPS_LOCK_IN(caps), .DEBOUNCE_IN(deb), .DEBOUNCE_DISCHARGE(dis),
    .HOST_TIMING_PULSE(htp), .DEV_SELECT_INPUTS(sel), .HOST_DATA_OUT(dout), .HOST_DATA_OE(oe),
    .KEY_READY_N(rdy_n), .KEY_HELD_N(held_n));
  kme_kbd_model kbd (.clk(clk), .key_a(ka), .key_b(kb), .key_on(kon), .drive(drv), .sense(sns),
    .discharge(dis), .debounce(deb));
  // Clock.
  initial begin
    forever #5 clk = ~clk;
  end
  // Timing pulse, four cycles high in eight, and the run limit.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    htp <= cyc[2];
    if (cyc == 60000) begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic await_ready;
    int n;
    n = 0;
    while (rdy_n !== 1'b0 && n < 2000) begin
      step(1);
      n++;
    end
    chk("ready", 8'h00, {7'h00, rdy_n});
  endtask
  task automatic read_key(input logic [7:0] exp);
    chk("idle enable", 8'h00, {7'h00, oe});
    while (htp !== 1'b0) step(1);
    sel = 4'hE;
    while (htp !== 1'b1) step(1);
    step(2);
    chk("enable", 8'h01, {7'h00, oe});
    chk("code", exp, dout);
    chk("ready clear", 8'h01, {7'h00, rdy_n});
    sel = 4'hF;
  endtask
  task automatic release_keys;
    int n;
    n = 0;
    kon = 2'h0;
    step(10);
    chk("held in debounce", 8'h00, {7'h00, held_n});
    while (held_n !== 1'b1 && n < 200) begin
      step(1);
      n++;
    end
    chk("held release", 8'h01, {7'h00, held_n});
  endtask
  task automatic key_cycle(input logic [6:0] idx, input logic [2:0] mods, input logic [7:0] exp);
    {ctrl, shift, caps} = mods;
    ka = idx;
    kon = 2'h1;
    await_ready();
    read_key(exp);
    step(40);
    chk("held", 8'h00, {7'h00, held_n});
    chk("no repeat", 8'h01, {7'h00, rdy_n});
    release_keys();
    {ctrl, shift, caps} = 3'h0;
  endtask
  task automatic t_lockout;
    ka = 7'h42;
    kb = 7'h57;
    kon = 2'h3;
    await_ready();
    read_key(8'h8A);
    kon = 2'h2;
    await_ready();
    read_key(8'h9F);
    release_keys();
  endtask
  task automatic t_nocode;
    {ctrl, shift} = 2'h3;
    step(800);
    chk("modifier only", 8'h01, {7'h00, rdy_n});
    {ctrl, shift} = 2'h0;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence.
  initial begin
    step(2);
    rst = 1'b0;
    t_lockout();
    t_nocode();
    key_cycle(7'h11, 3'h0, 8'h61);
    key_cycle(7'h11, 3'h1, 8'h41);
    key_cycle(7'h11, 3'h2, 8'h41);
    key_cycle(7'h11, 3'h4, 8'h01);
    key_cycle(7'h11, 3'h6, 8'h01);
    key_cycle(7'h38, 3'h4, 8'h80);
    key_cycle(7'h00, 3'h0, 8'h30);
    key_cycle(7'h0C, 3'h0, 8'h2C);
    key_cycle(7'h01, 3'h2, 8'h21);
    print_verdict();
  end
endmodule // tb_top
